// ---- rtl/port_config_preload_map.sv ----
// Preload mapping of image words into three ports' configuration fields
// What this block does
// - Word 82h feeds port 1, word 84h port 2: PM, VGA, vendor fields.
// - PM word bit 6 goes to offset 74h bit 14, Rx polarity disable.
// - PM word bits 5:0 go to offset 74h bits 13:8.
// - PM word bit 7 goes to offset 70h bit 31, VGA decode enable.
// - PM word bits 15:8 go to offset 88h bits 31:24.
// - Words 92h/94h fill slot capability D4h low half, ports 1 and 2.
// - Words A2h/A4h fill slot capability D4h high half, ports 1 and 2.
// - Words B0h/B2h/B4h fill offset 80h bits 15:0 of ports 0-2.
// - Words C0h/C2h/C4h fill offset 80h bits 31:16 of ports 0-2.
// - Replay words D0h-D4h bits 11:0 go to offset 70h bits 11:0.
// - Replay word bit 12 goes to offset 70h bit 12, user enable.
// - Replay word bits 14:13 go to offset 8Ch bits 25:24.
// - Words E0h/E2h bits 13:0 go to offset 70h bits 29:16.
// - Ack word bit 14 goes to offset 70h bit 30, user enable.
`timescale 1ns/100ps
module port_config_preload_map
  import preload_map_pkg::*;
#(
  parameter logic [11:0] REPLAY_BUILTIN = 12'h000,
  parameter logic [13:0] ACK_BUILTIN    = 14'h0000
) (
  // Clock and reset
  input  wire logic                  mclk_in,
  input  wire logic                  rst_in,
  // Preload image words
  input  wire logic                  load_valid_in,
  input  wire logic [7:0]            load_addr_in,
  input  wire logic [15:0]           load_data_in,
  input  wire logic                  load_done_in,
  // Configuration register port
  input  wire logic [9:0]            addr_in,
  input  wire logic [31:0]           wr_data_in,
  input  wire logic                  wr_in,
  input  wire logic                  rd_in,
  output logic      [31:0]           rd_data_out,
  // Status and timer values
  output logic                       cfg_ready_out,
  output logic      [2:0][11:0]      replay_limit_out,
  output logic      [2:0][13:0]      ack_limit_out
);
  import preload_map_pkg::*;

  logic [NUM_PORTS-1:0][NUM_REGS-1:0][31:0] cfg_ff;
  logic [NUM_PORTS-1:0][NUM_REGS-1:0][31:0] nxt_cfg;
  logic                                    ready_ff;
  logic [31:0]                             rd_data_ff;
  logic [2:0][11:0]                        replay_ff;
  logic [2:0][13:0]                        ack_ff;
  logic [2:0]                              bus_idx;
  logic [1:0]                              bus_port;
  logic                                    bus_hit;

  function automatic logic [2:0] reg_index(input logic [7:0] ofs);
    logic [2:0] idx;
    idx = IDX_NONE;
    unique case (ofs)
      OFS_LINK_TIMER: idx = IDX_LINK_TIMER;
      OFS_PM_CTRL:    idx = IDX_PM_CTRL;
      OFS_PHY_THREE:  idx = IDX_PHY_THREE;
      OFS_PHY_FIVE:   idx = IDX_PHY_FIVE;
      OFS_TS_REV:     idx = IDX_TS_REV;
      OFS_SLOT_CAP:   idx = IDX_SLOT_CAP;
      default:        idx = IDX_NONE;
    endcase
    return idx;
  endfunction

  // Word for port p sits at base + 2 * p, only for ports the kind covers
  function automatic logic word_hit(input logic [7:0] base,
                                    input logic [2:0] ports,
                                    input logic [7:0] addr,
                                    input int         p);
    logic [7:0] slot;
    slot = base + 8'(2 * p);
    return ports[p] && (addr == slot);
  endfunction

  assign bus_port = addr_in[9:8];
  assign bus_idx  = reg_index(addr_in[7:0]);
  // Access is held off until the image is fully applied
  assign bus_hit  = ready_ff && (bus_port < 2'h3) &&
                    (bus_idx != IDX_NONE);

  always_comb begin
    logic [15:0] d;
    d = load_data_in;
    nxt_cfg = cfg_ff;
    if (wr_in && bus_hit) begin
      nxt_cfg[bus_port][bus_idx] = wr_data_in;
    end
    // Late image words are ignored so they cannot undo software writes
    if (load_valid_in && !ready_ff) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        if (word_hit(PL_PM_BASE, PL_PM_PORTS, load_addr_in, p)) begin
          nxt_cfg[p][IDX_PM_CTRL][RX_POL_DIS_BIT] = d[W_RX_POL_BIT];
          nxt_cfg[p][IDX_PM_CTRL][PM_FIELD_LSB +: 6] = d[5:0];
          nxt_cfg[p][IDX_LINK_TIMER][VGA_DEC_BIT] = d[W_VGA_BIT];
          nxt_cfg[p][IDX_PHY_FIVE][PHY_FIVE_LSB +: 8] = d[15:8];
        end
        if (word_hit(PL_SLOT_LO_BASE, PL_SLOT_PORTS, load_addr_in, p)) begin
          nxt_cfg[p][IDX_SLOT_CAP][15:0] = d;
        end
        if (word_hit(PL_SLOT_HI_BASE, PL_SLOT_PORTS, load_addr_in, p)) begin
          nxt_cfg[p][IDX_SLOT_CAP][31:16] = d;
        end
        if (word_hit(PL_PHY_LO_BASE, PL_ALL_PORTS, load_addr_in, p)) begin
          nxt_cfg[p][IDX_PHY_THREE][15:0] = d;
        end
        if (word_hit(PL_PHY_HI_BASE, PL_ALL_PORTS, load_addr_in, p)) begin
          nxt_cfg[p][IDX_PHY_THREE][31:16] = d;
        end
        if (word_hit(PL_REPLAY_BASE, PL_ALL_PORTS, load_addr_in, p)) begin
          nxt_cfg[p][IDX_LINK_TIMER][11:0] = d[11:0];
          nxt_cfg[p][IDX_LINK_TIMER][REPLAY_EN_BIT] = d[12];
          nxt_cfg[p][IDX_TS_REV][TS_REV_LSB +: 2] =
            d[W_TS_REV_LSB +: 2];
        end
        if (word_hit(PL_ACK_BASE, PL_ACK_PORTS, load_addr_in, p)) begin
          nxt_cfg[p][IDX_LINK_TIMER][ACK_LSB +: 14] = d[13:0];
          nxt_cfg[p][IDX_LINK_TIMER][ACK_EN_BIT] = d[W_ACK_EN_BIT];
        end
      end
    end
  end

  // Bits no word covers stay at these values
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        cfg_ff[p][IDX_LINK_TIMER] <= RST_LINK_TIMER;
        cfg_ff[p][IDX_PM_CTRL]    <= RST_PM_CTRL;
        cfg_ff[p][IDX_PHY_THREE]  <= RST_PHY_THREE;
        cfg_ff[p][IDX_PHY_FIVE]   <= RST_PHY_FIVE;
        cfg_ff[p][IDX_TS_REV]     <= RST_TS_REV;
        cfg_ff[p][IDX_SLOT_CAP]   <= RST_SLOT_CAP;
      end
    end else begin
      cfg_ff <= nxt_cfg;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      ready_ff <= 1'b0;
    end else if (load_done_in) begin
      ready_ff <= 1'b1;
    end
  end

  // Read data stand for one cycle only; misses and early reads give zero
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      rd_data_ff <= 32'h0000_0000;
    end else if (rd_in && bus_hit) begin
      rd_data_ff <= cfg_ff[bus_port][bus_idx];
    end else begin
      rd_data_ff <= 32'h0000_0000;
    end
  end

  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      replay_ff <= {3{REPLAY_BUILTIN}};
      ack_ff    <= {3{ACK_BUILTIN}};
    end else begin
      for (int p = 0; p < NUM_PORTS; p++) begin
        replay_ff[p] <= cfg_ff[p][IDX_LINK_TIMER][REPLAY_EN_BIT] ?
                        cfg_ff[p][IDX_LINK_TIMER][11:0] :
                        REPLAY_BUILTIN;
        ack_ff[p]    <= cfg_ff[p][IDX_LINK_TIMER][ACK_EN_BIT] ?
                        cfg_ff[p][IDX_LINK_TIMER][ACK_LSB +: 14] :
                        ACK_BUILTIN;
      end
    end
  end

  assign rd_data_out      = rd_data_ff;
  assign cfg_ready_out    = ready_ff;
  assign replay_limit_out = replay_ff;
  assign ack_limit_out    = ack_ff;

  pm_word_port1_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    load_valid_in && !ready_ff && load_addr_in == 8'h82
    |=> cfg_ff[1][IDX_PM_CTRL][14:8] ==
        {$past(load_data_in[6]), $past(load_data_in[5:0])})
    else $error("PM word not placed in port 1 offset 74h");

  vga_phy_port2_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    load_valid_in && !ready_ff && load_addr_in == 8'h84
    |=> cfg_ff[2][IDX_PHY_FIVE][31:24] == $past(load_data_in[15:8])
        && cfg_ff[2][IDX_LINK_TIMER][31] == $past(load_data_in[7]))
    else $error("Port 2 VGA or vendor field not loaded");

  port0_no_pm_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    load_valid_in && load_addr_in == 8'h80 && !(wr_in && bus_hit)
    |=> $stable(cfg_ff[0][IDX_PM_CTRL]))
    else $error("Word 80h changed port 0 PM control");

  slot_halves_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    load_valid_in && !ready_ff && load_addr_in == 8'hA4
    |=> cfg_ff[2][IDX_SLOT_CAP][31:16] == $past(load_data_in)
        && $stable(cfg_ff[2][IDX_SLOT_CAP][15:0]))
    else $error("Slot capability high half of port 2 wrong");

  phy_three_low_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    load_valid_in && !ready_ff && load_addr_in == 8'hB2
    |=> cfg_ff[1][IDX_PHY_THREE][15:0] == $past(load_data_in))
    else $error("Port 1 offset 80h low half not loaded");

  replay_fields_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    load_valid_in && !ready_ff && load_addr_in == 8'hD4
    |=> cfg_ff[2][IDX_LINK_TIMER][12:0] == $past(load_data_in[12:0])
        && cfg_ff[2][IDX_TS_REV][25:24] == $past(load_data_in[14:13]))
    else $error("Port 2 replay word fields misplaced");

  ack_fields_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    load_valid_in && !ready_ff && load_addr_in == 8'hE2
    |=> cfg_ff[1][IDX_LINK_TIMER][30:16] == $past(load_data_in[14:0]))
    else $error("Port 1 ack latency word misplaced");

  early_read_zero_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    rd_in && !ready_ff |=> rd_data_out == 32'h0000_0000)
    else $error("Configuration read answered before load end");

  replay_builtin_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !cfg_ff[0][IDX_LINK_TIMER][12] ##1 !cfg_ff[0][IDX_LINK_TIMER][12]
    |-> replay_limit_out[0] == REPLAY_BUILTIN)
    else $error("Replay limit not built-in while user bit clear");

  ack_user_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    cfg_ff[1][IDX_LINK_TIMER][30]
    |=> ack_limit_out[1] == $past(cfg_ff[1][IDX_LINK_TIMER][29:16]))
    else $error("Ack limit ignores loaded value");

  pm_word_port2_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    load_valid_in && !ready_ff && load_addr_in == PL_PM_BASE + 8'h04
    |=> cfg_ff[2][IDX_PM_CTRL][14:8] == $past(load_data_in[6:0]))
    else $error("PM word not placed in port 2 offset 74h");

  vga_port1_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    load_valid_in && !ready_ff && load_addr_in == PL_PM_BASE + 8'h02
    |=> cfg_ff[1][IDX_LINK_TIMER][VGA_DEC_BIT] == $past(load_data_in[7]))
    else $error("Port 1 VGA decode enable not loaded");

  slot_low_port1_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    load_valid_in && !ready_ff && load_addr_in == PL_SLOT_LO_BASE + 8'h02
    |=> cfg_ff[1][IDX_SLOT_CAP][15:0] == $past(load_data_in)
        && $stable(cfg_ff[1][IDX_SLOT_CAP][31:16]))
    else $error("Slot capability low half of port 1 wrong");

  slot_port0_none_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    load_valid_in && load_addr_in == PL_SLOT_LO_BASE && !(wr_in && bus_hit)
    |=> $stable(cfg_ff[0][IDX_SLOT_CAP]))
    else $error("Word 90h changed port 0 slot capability");

  phy_three_high_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    load_valid_in && !ready_ff && load_addr_in == PL_PHY_HI_BASE + 8'h04
    |=> cfg_ff[2][IDX_PHY_THREE][31:16] == $past(load_data_in))
    else $error("Port 2 offset 80h high half not loaded");

  replay_port0_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    load_valid_in && !ready_ff && load_addr_in == PL_REPLAY_BASE
    |=> cfg_ff[0][IDX_LINK_TIMER][11:0] == $past(load_data_in[11:0])
        && cfg_ff[0][IDX_TS_REV][25:24] == $past(load_data_in[14:13]))
    else $error("Port 0 replay word fields misplaced");

  ack_port0_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    load_valid_in && !ready_ff && load_addr_in == PL_ACK_BASE
    |=> cfg_ff[0][IDX_LINK_TIMER][29:16] == $past(load_data_in[13:0])
        && cfg_ff[0][IDX_LINK_TIMER][30] == $past(load_data_in[14]))
    else $error("Port 0 ack latency word misplaced");

  ack_port2_none_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    load_valid_in && load_addr_in == PL_ACK_BASE + 8'h04
    && !(wr_in && bus_hit)
    |=> $stable(cfg_ff[2][IDX_LINK_TIMER]))
    else $error("Word E4h changed port 2 link timer");

  late_word_ignored_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    load_valid_in && ready_ff && !wr_in |=> $stable(cfg_ff))
    else $error("Image word applied after load end");

  ready_sticky_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    cfg_ready_out |=> cfg_ready_out)
    else $error("Ready dropped without reset");

  read_one_cycle_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !rd_in |=> rd_data_out == 32'h0000_0000)
    else $error("Read data stood longer than one cycle");

  replay_user_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    cfg_ff[2][IDX_LINK_TIMER][REPLAY_EN_BIT]
    |=> replay_limit_out[2] == $past(cfg_ff[2][IDX_LINK_TIMER][11:0]))
    else $error("Replay limit ignores loaded value");

  ack_builtin_a: assert property (
    @(posedge mclk_in) disable iff (rst_in)
    !cfg_ff[0][IDX_LINK_TIMER][ACK_EN_BIT]
    |=> ack_limit_out[0] == ACK_BUILTIN)
    else $error("Ack limit not built-in while user bit clear");

endmodule // port_config_preload_map

// ---- common/preload_map_pkg.sv ----
// Constants for the per-port configuration preload mapping
package preload_map_pkg;
  localparam int NUM_PORTS = 3;
  localparam int NUM_REGS  = 6;
  // Configuration offsets (byte addresses within a port's space)
  localparam logic [7:0] OFS_LINK_TIMER  = 8'h70;
  localparam logic [7:0] OFS_PM_CTRL     = 8'h74;
  localparam logic [7:0] OFS_PHY_THREE   = 8'h80;
  localparam logic [7:0] OFS_PHY_FIVE    = 8'h88;
  localparam logic [7:0] OFS_TS_REV      = 8'h8C;
  localparam logic [7:0] OFS_SLOT_CAP    = 8'hD4;
  // Storage index of each register
  localparam logic [2:0] IDX_LINK_TIMER  = 3'h0;
  localparam logic [2:0] IDX_PM_CTRL     = 3'h1;
  localparam logic [2:0] IDX_PHY_THREE   = 3'h2;
  localparam logic [2:0] IDX_PHY_FIVE    = 3'h3;
  localparam logic [2:0] IDX_TS_REV      = 3'h4;
  localparam logic [2:0] IDX_SLOT_CAP    = 3'h5;
  localparam logic [2:0] IDX_NONE        = 3'h7;
  // Reset values
  localparam logic [31:0] RST_LINK_TIMER = 32'h0000_0000;
  localparam logic [31:0] RST_PM_CTRL    = 32'h0000_0000;
  localparam logic [31:0] RST_PHY_THREE  = 32'h0000_0000;
  localparam logic [31:0] RST_PHY_FIVE   = 32'h0000_0000;
  localparam logic [31:0] RST_TS_REV     = 32'h0000_0000;
  localparam logic [31:0] RST_SLOT_CAP   = 32'h0000_0000;
  // Preload word addresses: base + 2 * port, with the ports each covers
  localparam logic [7:0] PL_PM_BASE      = 8'h80;
  localparam logic [2:0] PL_PM_PORTS     = 3'h6;
  localparam logic [7:0] PL_SLOT_LO_BASE = 8'h90;
  localparam logic [7:0] PL_SLOT_HI_BASE = 8'hA0;
  localparam logic [2:0] PL_SLOT_PORTS   = 3'h6;
  localparam logic [7:0] PL_PHY_LO_BASE  = 8'hB0;
  localparam logic [7:0] PL_PHY_HI_BASE  = 8'hC0;
  localparam logic [7:0] PL_REPLAY_BASE  = 8'hD0;
  localparam logic [2:0] PL_ALL_PORTS    = 3'h7;
  localparam logic [7:0] PL_ACK_BASE     = 8'hE0;
  localparam logic [2:0] PL_ACK_PORTS    = 3'h3;
  // Field positions in the target registers
  localparam int RX_POL_DIS_BIT  = 14;
  localparam int PM_FIELD_LSB    = 8;
  localparam int VGA_DEC_BIT     = 31;
  localparam int PHY_FIVE_LSB    = 24;
  localparam int REPLAY_EN_BIT   = 12;
  localparam int TS_REV_LSB      = 24;
  localparam int ACK_LSB         = 16;
  localparam int ACK_EN_BIT      = 30;
  // Field positions in the preload words
  localparam int W_RX_POL_BIT    = 6;
  localparam int W_VGA_BIT       = 7;
  localparam int W_TS_REV_LSB    = 13;
  localparam int W_ACK_EN_BIT    = 14;
endpackage : preload_map_pkg

// ---- testbench/image_rom_model.sv ----
// Behavioural configuration image memory that streams its preload words
`timescale 1ns/100ps
module image_rom_model (
  // Clock and reset
  input  wire logic        mclk_in,
  input  wire logic        rst_in,
  // Control from the bench
  input  wire logic        go_in,
  input  wire logic        slow_in,
  // Preload words
  output logic             load_valid_out,
  output logic [7:0]       load_addr_out,
  output logic [15:0]      load_data_out,
  output logic             load_done_out
);
  logic [15:0] image_mem [0:63];
  logic [7:0]  next_ff;
  logic        busy_ff;
  logic        gap_ff;

  // Idle cycles flip the word lines so stale data never looks valid
  always_ff @(posedge mclk_in or posedge rst_in) begin
    if (rst_in) begin
      busy_ff        <= 1'b0;
      gap_ff         <= 1'b0;
      next_ff        <= 8'h80;
      load_valid_out <= 1'b0;
      load_done_out  <= 1'b0;
      load_addr_out  <= 8'h00;
      load_data_out  <= 16'h0000;
    end else begin
      load_valid_out <= 1'b0;
      load_done_out  <= 1'b0;
      load_addr_out  <= ~load_addr_out;
      load_data_out  <= ~load_data_out;
      gap_ff         <= slow_in & ~gap_ff;
      if (go_in && !busy_ff) begin
        busy_ff <= 1'b1;
        next_ff <= 8'h80;
      end else if (busy_ff && !(slow_in && !gap_ff)) begin
        if (next_ff > 8'hE4) begin
          busy_ff       <= 1'b0;
          load_done_out <= 1'b1;
        end else begin
          load_valid_out <= 1'b1;
          load_addr_out  <= next_ff;
          load_data_out  <= image_mem[next_ff[6:1]];
          next_ff        <= next_ff + 8'h02;
        end
      end
    end
  end
endmodule // image_rom_model

// ---- testbench/test_port_config_preload_map.sv ----
// Self-checking bench for the configuration preload mapping
`timescale 1ns/100ps
module test_port_config_preload_map;
  import preload_map_pkg::*;
  localparam logic [11:0] RB = 12'h5A5;
  localparam logic [13:0] AB = 14'h1234;
  logic             mclk_in, rst_in, go, slow, lv, ld, wr_in, rd_in;
  logic             cfg_ready_out;
  logic [7:0]       la;
  logic [15:0]      ldat;
  logic [9:0]       addr_in;
  logic [31:0]      wr_data_in, rd_data_out, d;
  logic [2:0][11:0] replay_limit_out;
  logic [2:0][13:0] ack_limit_out;
  logic [15:0]      img [0:63];
  int               err_count, num_checks;

  image_rom_model img_u (.mclk_in(mclk_in), .rst_in(rst_in), .go_in(go),
    .slow_in(slow), .load_valid_out(lv), .load_addr_out(la),
    .load_data_out(ldat), .load_done_out(ld));
  port_config_preload_map #(.REPLAY_BUILTIN(RB), .ACK_BUILTIN(AB)) dut_u (
    .mclk_in(mclk_in), .rst_in(rst_in), .load_valid_in(lv),
    .load_addr_in(la), .load_data_in(ldat), .load_done_in(ld),
    .addr_in(addr_in), .wr_data_in(wr_data_in), .wr_in(wr_in),
    .rd_in(rd_in), .rd_data_out(rd_data_out),
    .cfg_ready_out(cfg_ready_out), .replay_limit_out(replay_limit_out),
    .ack_limit_out(ack_limit_out));

  initial begin
    mclk_in = 1'b0;
    forever #5 mclk_in = ~mclk_in;
  end

  function automatic logic [15:0] w(int a);
    return img[a[6:1]];
  endfunction

  function automatic logic [31:0] exp_reg(int p, logic [7:0] ofs);
    logic [15:0] pm, rp, ak;
    pm = (p > 0) ? w(8'h80 + 2 * p) : 16'h0000;
    rp = w(8'hD0 + 2 * p);
    ak = (p < 2) ? w(8'hE0 + 2 * p) : 16'h0000;
    case (ofs)
      8'h70:   return {pm[7], ak[14:0], 3'h0, rp[12:0]};
      8'h74:   return {17'h00000, pm[6:0], 8'h00};
      8'h80:   return {w(8'hC0 + 2 * p), w(8'hB0 + 2 * p)};
      8'h88:   return {pm[15:8], 24'h000000};
      8'h8C:   return {6'h00, rp[14:13], 24'h000000};
      8'hD4:   return (p > 0) ? {w(8'hA0 + 2 * p), w(8'h90 + 2 * p)} : 32'h0;
      default: return 32'h0000_0000;
    endcase
  endfunction

  task automatic check(logic [31:0] seen, logic [31:0] exp);
    num_checks++;
    if (seen !== exp) begin
      err_count++;
      $display("BAD %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic cfg_write(logic [1:0] p, logic [7:0] ofs, logic [31:0] v);
    @(posedge mclk_in);
    wr_in      <= 1'b1;
    addr_in    <= {p, ofs};
    wr_data_in <= v;
    @(posedge mclk_in);
    wr_in      <= 1'b0;
  endtask

  task automatic cfg_read(logic [1:0] p, logic [7:0] ofs,
                          output logic [31:0] v);
    @(posedge mclk_in);
    rd_in   <= 1'b1;
    addr_in <= {p, ofs};
    @(posedge mclk_in);
    rd_in   <= 1'b0;
    #1 v = rd_data_out;
  endtask

  task automatic run_load(logic s);
    foreach (img[i]) img_u.image_mem[i] = img[i];
    @(posedge mclk_in);
    slow <= s;
    go   <= 1'b1;
    @(posedge mclk_in);
    go   <= 1'b0;
    for (int i = 0; i < 400 && cfg_ready_out !== 1'b1; i++) begin
      @(posedge mclk_in);
    end
    repeat (2) @(posedge mclk_in);
  endtask

  task automatic check_all();
    logic [31:0] e;
    logic [11:0] r;
    logic [13:0] a;
    check({31'h0, cfg_ready_out}, 32'h0000_0001);
    for (int p = 0; p < 3; p++) begin
      cfg_read(p[1:0], 8'h70, d);
      check(d, exp_reg(p, 8'h70));
      cfg_read(p[1:0], 8'h74, d);
      check(d, exp_reg(p, 8'h74));
      cfg_read(p[1:0], 8'h80, d);
      check(d, exp_reg(p, 8'h80));
      cfg_read(p[1:0], 8'h88, d);
      check(d, exp_reg(p, 8'h88));
      cfg_read(p[1:0], 8'h8C, d);
      check(d, exp_reg(p, 8'h8C));
      cfg_read(p[1:0], 8'hD4, d);
      check(d, exp_reg(p, 8'hD4));
      e = exp_reg(p, 8'h70);
      r = e[12] ? e[11:0] : RB;
      a = e[30] ? e[29:16] : AB;
      check({20'h0, replay_limit_out[p]}, {20'h0, r});
      check({18'h0, ack_limit_out[p]}, {18'h0, a});
    end
  endtask

  task automatic do_reset();
    rst_in <= 1'b1;
    repeat (12) @(posedge mclk_in);
    rst_in <= 1'b0;
  endtask

  task automatic finish_test();
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge mclk_in);
    err_count++;
    finish_test();
  end

  initial begin
    {rst_in, go, slow, wr_in, rd_in} = 5'b10000;
    addr_in    = 10'h000;
    wr_data_in = 32'h0000_0000;
    void'($urandom(52836));
    do_reset();
    // Before the image is loaded the port is held off
    cfg_write(2'h1, 8'h70, 32'hFFFF_FFFF);
    cfg_read(2'h1, 8'h70, d);
    check(d, 32'h0000_0000);
    check({31'h0, cfg_ready_out}, 32'h0);
    check({20'h0, replay_limit_out[1]}, {20'h0, RB});
    $display("test hold-off done");
    foreach (img[i]) img[i] = 16'($urandom);
    run_load(1'b1);
    check_all();
    $display("test random slow load done");
    // Words offered after ready must be ignored
    foreach (img[i]) img_u.image_mem[i] = 16'($urandom);
    @(posedge mclk_in) go <= 1'b1;
    @(posedge mclk_in) go <= 1'b0;
    repeat (150) @(posedge mclk_in);
    check_all();
    $display("test late words done");
    cfg_write(2'h1, 8'h70, 32'h4ABC_1DEF);
    cfg_read(2'h1, 8'h70, d);
    check(d, 32'h4ABC_1DEF);
    check({20'h0, replay_limit_out[1]}, 32'h0000_0DEF);
    check({18'h0, ack_limit_out[1]}, 32'h0000_0ABC);
    cfg_write(2'h1, 8'h70, 32'h0ABC_0DEF);
    // Timers follow one edge after the write; look once they have settled
    @(posedge mclk_in);
    #1;
    check({20'h0, replay_limit_out[1]}, {20'h0, RB});
    check({18'h0, ack_limit_out[1]}, {18'h0, AB});
    cfg_read(2'h3, 8'h70, d);
    check(d, 32'h0000_0000);
    cfg_read(2'h0, 8'h78, d);
    check(d, 32'h0000_0000);
    $display("test software access done");
    // Second reset, every bit set, words back to back
    do_reset();
    foreach (img[i]) img[i] = 16'hFFFF;
    run_load(1'b0);
    check_all();
    $display("test full-ones fast load done");
    finish_test();
  end
endmodule // test_port_config_preload_map
